// ==== adrc_map.vh ====
// Register map, field positions, reset values and timing counts of the aperture delay ramp control.
// Function
// - Without SYSREF calibration, the coarse delay setting drives the coarse aperture delay.
// - Without SYSREF calibration, the fine delay setting drives the fine aperture delay.
// - Without SYSREF calibration, the sample clock invert bit inverts the conversion sampling clock.
// - A new fine delay value is accepted at any time.
// - Ramping steps one code, or four with step select set, per 384 cycles.
// - Step select applies only to coarse writes made with ramping on.
// - Without ramping, applied coarse delay follows a write within 2 cycles.
// - With ramping, applied coarse delay steps gradually until it equals the written value.
// - A finished SYSREF calibration reports its 17-bit delay, valid once done reads one.
// - Result holds invert in bit 16, coarse in bits 15:8, fine in 7:0.
`ifndef ADRC_MAP_VH
`define ADRC_MAP_VH

`define ADRC_ADDR_W          15
`define ADRC_DATA_W          24
`define ADRC_OFS_SETTING     15'h02B5
`define ADRC_OFS_RAMP_CTRL   15'h02B8
`define ADRC_OFS_CAL_STATUS  15'h02B0
`define ADRC_OFS_RAMP_STATUS 15'h02B9

`define ADRC_SET_INV_BIT     16
`define ADRC_SET_COARSE_HI   15
`define ADRC_SET_COARSE_LO   8
`define ADRC_SET_FINE_HI     7
`define ADRC_SET_FINE_LO     0
`define ADRC_RAMP_EN_BIT     0
`define ADRC_RAMP_SEL_BIT    1
`define ADRC_CAL_DONE_BIT    17

`define ADRC_RST_SETTING     17'h00000
`define ADRC_RST_RAMP_CTRL   2'h0

`define ADRC_RAMP_PERIOD     9'h180
`define ADRC_STEP_SMALL      8'h01
`define ADRC_STEP_LARGE      8'h04

`endif

// ==== adrc_ramp_step.v ====
// Coarse delay ramp engine: moves the applied coarse code toward the written target.
`timescale 1ns/10ps
`include "adrc_map.vh"
module adrc_ramp_step (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire       wr_i,
  input  wire       ramp_on_i,
  input  wire       step_sel_i,
  input  wire [7:0] target_i,
  output reg  [7:0] applied_o,
  output wire       busy_o
);

  reg       ramping_q;
  reg       step4_q;
  reg [7:0] target_q;
  reg [8:0] tick_q;
  wire [7:0] step;
  wire [7:0] diff_up;
  wire [7:0] diff_dn;
  wire       tick_end;

  // Step size is latched at write time so the select only affects ramped writes.
  assign step     = step4_q ? `ADRC_STEP_LARGE : `ADRC_STEP_SMALL;
  assign diff_up  = target_q - applied_o;
  assign diff_dn  = applied_o - target_q;
  assign tick_end = (tick_q == (`ADRC_RAMP_PERIOD - 9'h001));
  assign busy_o   = ramping_q;

  // Writes either load the target at once or arm a ramp from the present applied value.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ramping_q <= 1'b0;
      step4_q   <= 1'b0;
      target_q  <= 8'h00;
      tick_q    <= 9'h000;
      applied_o <= 8'h00;
    end else if (wr_i) begin
      target_q <= target_i;
      if (ramp_on_i) begin
        ramping_q <= (target_i != applied_o);
        step4_q   <= step_sel_i;
        tick_q    <= 9'h000;
      end else begin
        ramping_q <= 1'b0;
        applied_o <= target_i;
      end
    end else if (ramping_q) begin
      tick_q <= tick_end ? 9'h000 : tick_q + 9'h001;
      if (tick_end) begin
        // The last step takes only what is left, so the target is never passed.
        if (target_q > applied_o) begin
          applied_o <= (diff_up < step) ? target_q : applied_o + step;
          ramping_q <= (diff_up > step);
        end else begin
          applied_o <= (diff_dn < step) ? target_q : applied_o - step;
          ramping_q <= (diff_dn > step);
        end
      end
    end
  end

endmodule

// ==== adrc_top.v ====
// Aperture delay control: setting registers, calibration readback and applied delay outputs.
`timescale 1ns/10ps
`include "adrc_map.vh"
module adrc_top (
  input  wire                      clk_i,
  input  wire                      rstn_i,
  input  wire [`ADRC_ADDR_W-1:0]   reg_addr_i,
  input  wire                      reg_wr_i,
  input  wire                      reg_rd_i,
  input  wire [`ADRC_DATA_W-1:0]   reg_wdata_i,
  output reg  [`ADRC_DATA_W-1:0]   reg_rdata_o,
  input  wire                      sysref_cal_on_i,
  input  wire                      cal_delay_done_i,
  input  wire [16:0]               cal_delay_value_i,
  input  wire                      adc_cal_on_i,
  input  wire                      serial_link_on_i,
  output reg  [7:0]                coarse_delay_o,
  output reg  [7:0]                fine_delay_o,
  output reg                       sample_clock_invert_o,
  output wire                      ramp_busy_o
);

  // Stored settings, ramp control bits and the captured calibration result.
  reg  [7:0]  coarse_setting_q;
  reg  [7:0]  fine_setting_q;
  reg         invert_q;
  reg         ramp_on_q;
  reg         ramp_sel_q;
  reg         cal_done_q;
  reg  [16:0] cal_result_q;

  // Next values of the applied outputs and of the read data.
  reg  [7:0]  coarse_delay_d;
  reg  [7:0]  fine_delay_d;
  reg         invert_d;
  reg  [`ADRC_DATA_W-1:0] rdata_d;

  // Decoded strobes and the coarse code coming out of the ramp engine.
  wire        hit_setting;
  wire        hit_ramp;
  wire        wr_setting;
  wire        wr_ramp;
  wire        cal_valid;
  wire [7:0]  coarse_ramped;

  // Reset images of the two writable registers.
  localparam [16:0] RST_SETTING   = `ADRC_RST_SETTING;
  localparam [1:0]  RST_RAMP_CTRL = `ADRC_RST_RAMP_CTRL;

  // Reset values of the single fields, cut from the images above.
  localparam [7:0]  RST_COARSE    = RST_SETTING[`ADRC_SET_COARSE_HI:`ADRC_SET_COARSE_LO];
  localparam [7:0]  RST_FINE      = RST_SETTING[`ADRC_SET_FINE_HI:`ADRC_SET_FINE_LO];
  localparam [0:0]  RST_INVERT    = RST_SETTING[`ADRC_SET_INV_BIT];
  localparam [0:0]  RST_RAMP_ON   = RST_RAMP_CTRL[`ADRC_RAMP_EN_BIT];
  localparam [0:0]  RST_RAMP_SEL  = RST_RAMP_CTRL[`ADRC_RAMP_SEL_BIT];

  // Address decode of the two writable registers.
  assign hit_setting = (reg_addr_i == `ADRC_OFS_SETTING);
  assign hit_ramp    = (reg_addr_i == `ADRC_OFS_RAMP_CTRL);

  // Write strobes; writes to any other address are ignored.
  assign wr_setting  = reg_wr_i && hit_setting;
  assign wr_ramp     = reg_wr_i && hit_ramp;

  // A calibration result counts only while calibration is on and reports done.
  assign cal_valid   = sysref_cal_on_i && cal_delay_done_i;

  // Coarse setting register: the written target, read back as written.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      coarse_setting_q <= RST_COARSE;
    end else if (wr_setting) begin
      coarse_setting_q <= reg_wdata_i[`ADRC_SET_COARSE_HI:`ADRC_SET_COARSE_LO];
    end
  end

  // Fine setting register; a new value is taken on every write, whatever else runs.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fine_setting_q <= RST_FINE;
    end else if (wr_setting) begin
      fine_setting_q <= reg_wdata_i[`ADRC_SET_FINE_HI:`ADRC_SET_FINE_LO];
    end
  end

  // Invert setting register; software must hold it still while calibration or the link runs.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      invert_q <= RST_INVERT;
    end else if (wr_setting) begin
      invert_q <= reg_wdata_i[`ADRC_SET_INV_BIT];
    end
  end

  // Ramp enable bit: when set coarse writes ramp, when clear they apply directly.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ramp_on_q <= RST_RAMP_ON;
    end else if (wr_ramp) begin
      ramp_on_q <= reg_wdata_i[`ADRC_RAMP_EN_BIT];
    end
  end

  // Ramp step select bit; the engine latches it at each ramped coarse write.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ramp_sel_q <= RST_RAMP_SEL;
    end else if (wr_ramp) begin
      ramp_sel_q <= reg_wdata_i[`ADRC_RAMP_SEL_BIT];
    end
  end

  // Ramp engine shapes the coarse code actually applied.
  adrc_ramp_step u_ramp (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .wr_i       (wr_setting),
    .ramp_on_i  (ramp_on_q),
    .step_sel_i (ramp_sel_q),
    .target_i   (reg_wdata_i[`ADRC_SET_COARSE_HI:`ADRC_SET_COARSE_LO]),
    .applied_o  (coarse_ramped),
    .busy_o     (ramp_busy_o)
  );

  // Done flag for the status register, registered once from the qualified done.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_done_q <= 1'b0;
    end else begin
      cal_done_q <= cal_valid;
    end
  end

  // Calibration result is captured while valid and kept after done drops.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_result_q <= 17'h00000;
    end else if (cal_valid) begin
      cal_result_q <= cal_delay_value_i;
    end
  end

  // Next applied values: the calibration result while calibration owns the delay, else the manual path.
  always @* begin
    if (sysref_cal_on_i) begin
      coarse_delay_d = cal_result_q[`ADRC_SET_COARSE_HI:`ADRC_SET_COARSE_LO];
      fine_delay_d   = cal_result_q[`ADRC_SET_FINE_HI:`ADRC_SET_FINE_LO];
      invert_d       = cal_result_q[`ADRC_SET_INV_BIT];
    end else begin
      coarse_delay_d = coarse_ramped;
      fine_delay_d   = fine_setting_q;
      invert_d       = invert_q;
    end
  end

  // Applied coarse delay register.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      coarse_delay_o <= 8'h00;
    end else begin
      coarse_delay_o <= coarse_delay_d;
    end
  end

  // Applied fine delay register.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fine_delay_o <= 8'h00;
    end else begin
      fine_delay_o <= fine_delay_d;
    end
  end

  // Applied sampling clock inversion register.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_clock_invert_o <= 1'b0;
    end else begin
      sample_clock_invert_o <= invert_d;
    end
  end

  // Read multiplexer; unmapped addresses and reserved bits read as zero.
  always @* begin
    rdata_d = 24'h000000;
    case (reg_addr_i)
      `ADRC_OFS_SETTING: begin
        rdata_d[`ADRC_SET_INV_BIT]                         = invert_q;
        rdata_d[`ADRC_SET_COARSE_HI:`ADRC_SET_COARSE_LO]   = coarse_setting_q;
        rdata_d[`ADRC_SET_FINE_HI:`ADRC_SET_FINE_LO]       = fine_setting_q;
      end
      `ADRC_OFS_RAMP_CTRL: begin
        rdata_d[`ADRC_RAMP_EN_BIT]  = ramp_on_q;
        rdata_d[`ADRC_RAMP_SEL_BIT] = ramp_sel_q;
      end
      `ADRC_OFS_CAL_STATUS: begin
        rdata_d[`ADRC_CAL_DONE_BIT] = cal_done_q;
        if (cal_done_q) begin
          rdata_d[16:0] = cal_result_q;
        end
      end
      `ADRC_OFS_RAMP_STATUS: begin
        rdata_d[7:0] = coarse_ramped;
        rdata_d[8]   = ramp_busy_o;
        rdata_d[9]   = adc_cal_on_i;
        rdata_d[10]  = serial_link_on_i;
      end
      default: begin
        rdata_d = 24'h000000;
      end
    endcase
  end

  // Read data is registered on a read strobe and held otherwise.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 24'h000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

endmodule

// ==== adrc_chk_sva.sv ====
// Checker tying the applied delay outputs to register writes and calibration inputs.
`timescale 1ns/10ps
`include "adrc_map.vh"
module adrc_chk (
  input logic        clk_i,
  input logic        rstn_i,
  input logic [14:0] reg_addr_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [23:0] reg_wdata_i,
  input logic [23:0] reg_rdata_o,
  input logic        sysref_cal_on_i,
  input logic        cal_delay_done_i,
  input logic [16:0] cal_delay_value_i,
  input logic [7:0]  coarse_delay_o,
  input logic [7:0]  fine_delay_o,
  input logic        sample_clock_invert_o,
  input logic        ramp_busy_o
);
  logic [1:0] ramp_q;
  wire        cal_w = sysref_cal_on_i && cal_delay_done_i;
  wire [16:0] app_w = {sample_clock_invert_o, coarse_delay_o, fine_delay_o};
  // Shadow of the ramp control bits.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      ramp_q <= 2'h0;
    else if (reg_wr_i && reg_addr_i == `ADRC_OFS_RAMP_CTRL)
      ramp_q <= reg_wdata_i[1:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // A setting write, then a cycle with no write and one more cycle, all with calibration off.
  sequence s_set;
    reg_wr_i && reg_addr_i == `ADRC_OFS_SETTING && !sysref_cal_on_i
    ##1 !reg_wr_i && !sysref_cal_on_i ##1 !sysref_cal_on_i;
  endsequence
  property p_fine; s_set |-> fine_delay_o == $past(reg_wdata_i[7:0], 2); endproperty
  a_fine: assert property (p_fine) else $error("fine delay wrong");
  property p_inv; s_set |-> sample_clock_invert_o == $past(reg_wdata_i[16], 2); endproperty
  a_inv: assert property (p_inv) else $error("invert wrong");
  property p_direct; (!ramp_q[0] && !ramp_busy_o) ##0 s_set |-> coarse_delay_o == $past(reg_wdata_i[15:8], 2); endproperty
  a_direct: assert property (p_direct) else $error("coarse not direct");
  property p_go; (ramp_q[0] && !ramp_busy_o && reg_wdata_i[15:8] != coarse_delay_o) ##0 s_set |-> ramp_busy_o; endproperty
  a_go: assert property (p_go) else $error("ramp did not start");
  property p_slew;
    !sysref_cal_on_i && $past(!sysref_cal_on_i) && $past(!sysref_cal_on_i, 2) && $past(ramp_busy_o, 2)
    |-> 8'(coarse_delay_o - $past(coarse_delay_o) + 8'h04) <= 8'h08;
  endproperty
  a_slew: assert property (p_slew) else $error("ramp step too large");
  property p_cal; (cal_w && $stable(cal_delay_value_i)) [*4] |-> app_w == cal_delay_value_i; endproperty
  a_cal: assert property (p_cal) else $error("calibration result not applied");
  property p_stat;
    reg_rd_i && reg_addr_i == `ADRC_OFS_CAL_STATUS && cal_w && $past(cal_w) && $stable(cal_delay_value_i)
    |=> reg_rdata_o == {6'h00, 1'b1, $past(cal_delay_value_i)};
  endproperty
  a_stat: assert property (p_stat) else $error("calibration status wrong");
  property p_unmap; reg_rd_i && reg_addr_i == 15'h0000 |=> reg_rdata_o == 24'h000000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind adrc_top adrc_chk u_chk (
  .clk_i                 (clk_i),
  .rstn_i                (rstn_i),
  .reg_addr_i            (reg_addr_i),
  .reg_wr_i              (reg_wr_i),
  .reg_rd_i              (reg_rd_i),
  .reg_wdata_i           (reg_wdata_i),
  .reg_rdata_o           (reg_rdata_o),
  .sysref_cal_on_i       (sysref_cal_on_i),
  .cal_delay_done_i      (cal_delay_done_i),
  .cal_delay_value_i     (cal_delay_value_i),
  .coarse_delay_o        (coarse_delay_o),
  .fine_delay_o          (fine_delay_o),
  .sample_clock_invert_o (sample_clock_invert_o),
  .ramp_busy_o           (ramp_busy_o)
);

// ==== tb.sv ====
// Self-checking bench of the aperture delay control block.
`timescale 1ns/10ps
`include "adrc_map.vh"
module tb;
  logic        clk_i, rstn_i, reg_wr_i, reg_rd_i, sysref_cal_on_i, cal_delay_done_i;
  logic        adc_cal_on_i = 1'b0;
  logic        serial_link_on_i = 1'b0;
  logic [14:0] reg_addr_i;
  logic [23:0] reg_wdata_i;
  logic [16:0] cal_delay_value_i, v;
  wire  [23:0] reg_rdata_o;
  wire  [7:0]  coarse_delay_o, fine_delay_o;
  wire         sample_clock_invert_o, ramp_busy_o;
  wire  [23:0] app = {7'h00, sample_clock_invert_o, coarse_delay_o, fine_delay_o};
  int          miscompares, n_tests, cyc;
  adrc_top u_dut (.*);
  // Clock of 100 ns period.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [14:0] a, logic [23:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [14:0] a, logic [23:0] e, string n);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    chk(n, e, reg_rdata_o);
  endtask
  // Applied coarse code after k ramp steps, never passing the target.
  function automatic logic [7:0] ramp_at(logic [7:0] f, logic [7:0] to, logic [7:0] s, int k);
    for (int i = 0; i < k; i++)
      if (f < to) f = (to - f < s) ? to : f + s;
      else if (f > to) f = (f - to < s) ? to : f - s;
    return f;
  endfunction
  // Writes a ramp target and samples the applied code mid-way between steps.
  task automatic ramp(logic [7:0] f, logic [7:0] to, logic [7:0] s, int n);
    wr(`ADRC_OFS_SETTING, {8'h00, to, 8'h00});
    repeat (198) @(posedge clk_i);
    for (int k = 0; k < n; k++) begin
      chk("coarse", {16'h0000, ramp_at(f, to, s, k)}, {16'h0000, coarse_delay_o});
      repeat (384) @(posedge clk_i);
    end
  endtask
  // Main sequence: reset values, direct writes, ramps, retarget, calibration.
  initial begin
    rstn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 15'h0000;
    reg_wdata_i = 24'h000000;
    sysref_cal_on_i = 1'b0;
    cal_delay_done_i = 1'b0;
    cal_delay_value_i = 17'h00000;
    void'($urandom(32'h2296E31D));
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(`ADRC_OFS_SETTING, 24'h000000, "setting");
    rd(`ADRC_OFS_RAMP_CTRL, 24'h000000, "ramp_ctrl");
    rd(15'h0000, 24'h000000, "unmapped");
    wr(`ADRC_OFS_RAMP_CTRL, 24'h000002);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 17'h1FFFF : 17'($urandom);
      wr(`ADRC_OFS_SETTING, {7'h00, v});
      repeat (2) @(posedge clk_i);
      chk("applied", {7'h00, v}, app);
      rd(`ADRC_OFS_SETTING, {7'h00, v}, "setting");
    end
    wr(`ADRC_OFS_SETTING, 24'h000A05);
    wr(`ADRC_OFS_RAMP_CTRL, 24'h000001);
    ramp(8'h0A, 8'h0D, 8'h01, 5);
    chk("busy", 24'h000000, {23'h000000, ramp_busy_o});
    wr(`ADRC_OFS_RAMP_CTRL, 24'h000003);
    rd(`ADRC_OFS_RAMP_CTRL, 24'h000003, "ramp_ctrl");
    ramp(8'h0D, 8'h04, 8'h04, 4);
    ramp(8'h04, 8'h20, 8'h04, 2);
    ramp(8'h0C, 8'h06, 8'h04, 3);
    chk("busy", 24'h000000, {23'h000000, ramp_busy_o});
    v = 17'($urandom);
    cal_delay_value_i <= v;
    sysref_cal_on_i <= 1'b1;
    cal_delay_done_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("cal_applied", {7'h00, v}, app);
    rd(`ADRC_OFS_CAL_STATUS, {6'h00, 1'b1, v}, "cal_status");
    sysref_cal_on_i <= 1'b0;
    cal_delay_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("applied", 24'h000600, app);
    // Enables up: invert left alone, coarse moved one code per direct write.
    adc_cal_on_i <= 1'b1;
    serial_link_on_i <= 1'($urandom);
    wr(`ADRC_OFS_RAMP_CTRL, 24'h000000);
    for (int i = 1; i <= 3; i++) begin
      v = {1'b0, 8'h06 + 8'(i), 8'($urandom)};
      wr(`ADRC_OFS_SETTING, {7'h00, v});
      repeat (2) @(posedge clk_i);
      chk("applied", {7'h00, v}, app);
      rd(`ADRC_OFS_RAMP_STATUS, {13'h0000, serial_link_on_i, 1'b1, 1'b0, v[15:8]}, "ramp_status");
    end
    summarize();
  end
endmodule
